// ---- hw/irq_gate_pkg.sv ----
/*
 * Package for the core interrupt gating block: register indices, field positions,
 * reset values and masks.
 * Assumes a byte-wide register port where the printed offsets are the addresses.
 */
package irq_gate_pkg;
    localparam logic [7:0] ADDR_CORE_CTRL   = 8'h0b;
    localparam logic [7:0] ADDR_PERIPH_EN   = 8'h8c;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h90;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h91;
    localparam logic [7:0] ADDR_EDGE_SELECT = 8'h92;
    localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h93;

    localparam int MASTER_BIT  = 7;
    localparam int GROUP_BIT   = 6;
    localparam int T0EN_BIT    = 5;
    localparam int EXTEN_BIT   = 4;
    localparam int PCEN_BIT    = 3;
    localparam int T0FLAG_BIT  = 2;
    localparam int EXTFLAG_BIT = 1;
    localparam int PCFLAG_BIT  = 0;

    localparam logic [7:0] CORE_CTRL_RESET  = 8'h00;
    localparam logic [7:0] PERIPH_EN_RESET  = 8'h00;
    localparam logic [7:0] PERIPH_EN_MASK   = 8'h4f;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;
    localparam logic       EDGE_SEL_RESET   = 1'b1;
    localparam int         NUM_PERIPH       = 5;
    localparam int         NUM_STATUS       = 3;
    localparam logic [1:0] SYNC_FILL        = 2'h3;
endpackage

// ---- hw/edge_catcher.sv ----
/*
 * Synchroniser and edge detector for the external interrupt pin and the four
 * port-change pins.
 * Assumes the pins are asynchronous to core_clk and held for at least two cycles.
 */
module edge_catcher (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       extIrqPin,
    input  wire logic [3:0] portChangePins,
    input  wire logic       edgeSelect,
    output logic            extEdge,
    output logic            portChange
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] sync;
        logic [4:0] prev;
        logic [1:0] fill;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;
    logic        primed;

    // History counts as filled only once the previous stage holds a real pin sample.
    assign primed = (s_q.fill == irq_gate_pkg::SYNC_FILL);

    always_comb begin
        s_d        = s_q;
        s_d.meta   = {portChangePins, extIrqPin};
        s_d.sync   = s_q.meta;
        s_d.prev   = s_q.sync;
        s_d.fill   = primed ? s_q.fill : s_q.fill + 2'h1;
    end

    // Edges are suppressed until the history is filled so reset does not fake an event.
    always_comb begin
        extEdge    = primed && (edgeSelect ? (s_q.sync[0] && !s_q.prev[0])
                                               : (!s_q.sync[0] && s_q.prev[0]));
        portChange = primed && (s_q.sync[4:1] != s_q.prev[4:1]);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ---- hw/core_interrupt_gating.sv ----
/*
 * Interrupt enable and flag logic of a small controller core: core control
 * register, peripheral enable register, flag capture and the CPU request.
 * Assumes peripheral flag and timer overflow pulses come from logic on core_clk,
 * and the pins arrive asynchronously.
 */
// Strobed register access is this design's own decision.
module core_interrupt_gating (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    input  wire logic       timer0Overflow,
    input  wire logic [4:0] periphEvent,
    input  wire logic       extIrqPin,
    input  wire logic [3:0] portChangePins,
    output logic            cpuIrq,
    output logic            irqLine
);
    typedef struct packed {
        logic [7:0] coreCtrl;
        logic [7:0] periphEn;
        logic [4:0] periphFlag;
        logic [2:0] status;
        logic [2:0] mask;
        logic       edgeSel;
        logic [7:0] rdata;
        logic       cpuIrq;
        logic       irqLine;
    } gate_state_t;

    gate_state_t s_q;
    gate_state_t s_d;
    logic        extEdge;
    logic        portChange;
    logic [4:0]  periphEnBits;
    logic        wrCore;
    logic        wrPeriph;
    logic        reqNext;
    logic [2:0]  events;
    logic        wrStatus;
    logic        wrMask;
    logic        wrEdge;
    logic        wrFlag;
    logic [4:0]  periphFlagNext;
    logic [2:0]  statusNext;

    edge_catcher u_edges (
        .core_clk       (core_clk),
        .rstn           (rstn),
        .extIrqPin      (extIrqPin),
        .portChangePins (portChangePins),
        .edgeSelect     (s_q.edgeSel),
        .extEdge        (extEdge),
        .portChange     (portChange)
    );

    // Peripheral event index order: timer1, timer2, capcomp, serial, converter.
    assign periphEnBits = {s_q.periphEn[6], s_q.periphEn[3:0]};
    assign wrCore       = regWrite && (regAddr == irq_gate_pkg::ADDR_CORE_CTRL);
    assign wrPeriph     = regWrite && (regAddr == irq_gate_pkg::ADDR_PERIPH_EN);
    assign events       = {timer0Overflow, extEdge, portChange};
    assign wrStatus     = regWrite && (regAddr == irq_gate_pkg::ADDR_IRQ_STATUS);
    assign wrMask       = regWrite && (regAddr == irq_gate_pkg::ADDR_IRQ_MASK);
    assign wrEdge       = regWrite && (regAddr == irq_gate_pkg::ADDR_EDGE_SELECT);
    assign wrFlag       = regWrite && (regAddr == irq_gate_pkg::ADDR_PERIPH_FLAG);

    // Each sticky bit lets its event win over a write-one clear in the same cycle,
    // so an event landing during the clear is never lost.
    for (genvar i = 0; i < irq_gate_pkg::NUM_PERIPH; i++) begin : g_periph_flag
        assign periphFlagNext[i] = periphEvent[i]
                                || (s_q.periphFlag[i] && !(wrFlag && regWdata[i]));
    end

    for (genvar i = 0; i < irq_gate_pkg::NUM_STATUS; i++) begin : g_status_flag
        assign statusNext[i] = events[i] || (s_q.status[i] && !(wrStatus && regWdata[i]));
    end

    always_comb begin
        s_d = s_q;
        if (wrCore) begin
            s_d.coreCtrl = regWdata;
        end
        // Set wins over a software clear landing in the same cycle.
        if (timer0Overflow) begin
            s_d.coreCtrl[irq_gate_pkg::T0FLAG_BIT] = 1'b1;
        end
        if (extEdge) begin
            s_d.coreCtrl[irq_gate_pkg::EXTFLAG_BIT] = 1'b1;
        end
        if (portChange) begin
            s_d.coreCtrl[irq_gate_pkg::PCFLAG_BIT] = 1'b1;
        end
        if (wrPeriph) begin
            s_d.periphEn = regWdata & irq_gate_pkg::PERIPH_EN_MASK;
        end
        s_d.periphFlag = periphFlagNext;
        s_d.status     = statusNext;
        if (wrMask) begin
            s_d.mask = regWdata[2:0];
        end
        if (wrEdge) begin
            s_d.edgeSel = regWdata[0];
        end
        s_d.rdata = irq_gate_pkg::ZERO_BYTE;
        if (regRead) begin
            case (regAddr)
                irq_gate_pkg::ADDR_CORE_CTRL:   s_d.rdata = s_q.coreCtrl;
                irq_gate_pkg::ADDR_PERIPH_EN:   s_d.rdata = s_q.periphEn;
                irq_gate_pkg::ADDR_PERIPH_FLAG: s_d.rdata = {3'h0, s_q.periphFlag};
                irq_gate_pkg::ADDR_IRQ_STATUS:  s_d.rdata = {5'h00, s_q.status};
                irq_gate_pkg::ADDR_IRQ_MASK:    s_d.rdata = {5'h00, s_q.mask};
                irq_gate_pkg::ADDR_EDGE_SELECT: s_d.rdata = {7'h00, s_q.edgeSel};
                default:                        s_d.rdata = irq_gate_pkg::ZERO_BYTE;
            endcase
        end
        s_d.cpuIrq  = reqNext;
        s_d.irqLine = |(s_q.status & s_q.mask);
    end

    // The request is computed from present state so it trails a flag by one cycle.
    always_comb begin
        reqNext = s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && (
            (s_q.coreCtrl[irq_gate_pkg::T0EN_BIT]  && s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT])
         || (s_q.coreCtrl[irq_gate_pkg::EXTEN_BIT] && s_q.coreCtrl[irq_gate_pkg::EXTFLAG_BIT])
         || (s_q.coreCtrl[irq_gate_pkg::PCEN_BIT]  && s_q.coreCtrl[irq_gate_pkg::PCFLAG_BIT])
         || (s_q.coreCtrl[irq_gate_pkg::GROUP_BIT] && |(s_q.periphFlag & periphEnBits)));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.coreCtrl <= irq_gate_pkg::CORE_CTRL_RESET;
            s_q.periphEn <= irq_gate_pkg::PERIPH_EN_RESET;
            s_q.edgeSel  <= irq_gate_pkg::EDGE_SEL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign cpuIrq   = s_q.cpuIrq;
    assign irqLine  = s_q.irqLine;

    // Every check except a_periph_unimpl looks one edge after its cause, because flags and the request are registered.
    a_master_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
        !s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] |=> !cpuIrq)
        else $error("request while master enable clear");

    a_master_allows: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::T0EN_BIT]
        && s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT] |=> cpuIrq)
        else $error("enabled timer0 flag did not request");

    a_req_full: assert property (@(posedge core_clk) disable iff (!rstn)
        cpuIrq == $past(s_q.coreCtrl[irq_gate_pkg::MASTER_BIT]
            && (|(s_q.coreCtrl[irq_gate_pkg::T0EN_BIT -: 3]
                  & s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT -: 3])
            || (s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
                && |(s_q.periphFlag & {s_q.periphEn[6], s_q.periphEn[3:0]})))))
        else $error("request differs from flag and enable terms");

    a_t0_flag_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        timer0Overflow |=> s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT])
        else $error("timer0 flag not set");

    a_t0_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT] && !wrCore
        |=> s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT])
        else $error("timer0 flag lost");

    a_t0_ignores_en: assert property (@(posedge core_clk) disable iff (!rstn)
        timer0Overflow && !s_q.coreCtrl[irq_gate_pkg::T0EN_BIT]
        && !s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] |=> s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT])
        else $error("timer0 flag gated by enable");

    a_t0_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        wrCore && !regWdata[irq_gate_pkg::T0FLAG_BIT] && !timer0Overflow
        |=> !s_q.coreCtrl[irq_gate_pkg::T0FLAG_BIT])
        else $error("timer0 flag not cleared by software");

    a_ext_flag_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        extEdge |=> s_q.coreCtrl[irq_gate_pkg::EXTFLAG_BIT])
        else $error("external flag not set");

    a_ext_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::EXTFLAG_BIT] && !wrCore
        |=> s_q.coreCtrl[irq_gate_pkg::EXTFLAG_BIT])
        else $error("external flag lost");

    a_ext_no_edge: assert property (@(posedge core_clk) disable iff (!rstn)
        !extEdge && !wrCore |=> $stable(s_q.coreCtrl[irq_gate_pkg::EXTFLAG_BIT]))
        else $error("external flag moved without an edge");

    a_pc_flag_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        portChange |=> s_q.coreCtrl[irq_gate_pkg::PCFLAG_BIT])
        else $error("port change flag not set");

    a_pc_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::PCFLAG_BIT] && !wrCore
        |=> s_q.coreCtrl[irq_gate_pkg::PCFLAG_BIT])
        else $error("port change flag lost");

    a_pc_no_change: assert property (@(posedge core_clk) disable iff (!rstn)
        !portChange && !wrCore |=> $stable(s_q.coreCtrl[irq_gate_pkg::PCFLAG_BIT]))
        else $error("port change flag moved without a change");

    a_core_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wrCore && !timer0Overflow && !extEdge && !portChange
        |=> s_q.coreCtrl == $past(regWdata))
        else $error("core control write lost");

    a_flag_ignores_en: assert property (@(posedge core_clk) disable iff (!rstn)
        periphEvent != 5'h00 |=> (s_q.periphFlag & $past(periphEvent)) == $past(periphEvent))
        else $error("peripheral flag not set by its event");

    a_periph_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        !wrFlag |=> (s_q.periphFlag & $past(s_q.periphFlag)) == $past(s_q.periphFlag))
        else $error("peripheral flag lost");

    a_periph_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        wrFlag && periphEvent == 5'h00 |=> (s_q.periphFlag & $past(regWdata[4:0])) == 5'h00)
        else $error("peripheral flag not cleared by write of one");

    a_group_gates: assert property (@(posedge core_clk) disable iff (!rstn)
        !s_q.coreCtrl[irq_gate_pkg::GROUP_BIT] && s_q.coreCtrl[5:0] == 6'h00 |=> !cpuIrq)
        else $error("peripheral request without group enable");

    a_req_equation: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
        && s_q.periphFlag[4] && s_q.periphEn[6] |=> cpuIrq)
        else $error("enabled converter flag did not request");

    a_serial_req: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
        && s_q.periphFlag[3] && s_q.periphEn[3] |=> cpuIrq)
        else $error("enabled serial flag did not request");

    a_capcomp_req: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
        && s_q.periphFlag[2] && s_q.periphEn[2] |=> cpuIrq)
        else $error("enabled capture compare flag did not request");

    a_timer2_req: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
        && s_q.periphFlag[1] && s_q.periphEn[1] |=> cpuIrq)
        else $error("enabled timer2 flag did not request");

    a_timer1_req: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.coreCtrl[irq_gate_pkg::MASTER_BIT] && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]
        && s_q.periphFlag[0] && s_q.periphEn[0] |=> cpuIrq)
        else $error("enabled timer1 flag did not request");

    a_periph_unimpl: assert property (@(posedge core_clk) disable iff (!rstn)
        s_q.periphEn[7] == 1'b0 && s_q.periphEn[5:4] == 2'h0)
        else $error("unimplemented enable bit set");

    a_periph_en_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wrPeriph |=> s_q.periphEn == ($past(regWdata) & irq_gate_pkg::PERIPH_EN_MASK))
        else $error("peripheral enable write wrong");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !regRead |=> regRdata == irq_gate_pkg::ZERO_BYTE)
        else $error("read data not zero outside a read");

    a_rdata_core: assert property (@(posedge core_clk) disable iff (!rstn)
        regRead && regAddr == irq_gate_pkg::ADDR_CORE_CTRL |=> regRdata == $past(s_q.coreCtrl))
        else $error("core control read wrong");

    a_rdata_unimpl: assert property (@(posedge core_clk) disable iff (!rstn)
        regRead && regAddr == irq_gate_pkg::ADDR_PERIPH_EN
        |=> regRdata[7] == 1'b0 && regRdata[5:4] == 2'h0)
        else $error("unimplemented enable bit read as one");

    a_status_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        events != 3'h0 |=> (s_q.status & $past(events)) == $past(events))
        else $error("status bit not set by its event");

    a_irq_line_eq: assert property (@(posedge core_clk) disable iff (!rstn)
        irqLine == $past(|(s_q.status & s_q.mask)))
        else $error("interrupt line differs from status and mask");

    a_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wrMask |=> s_q.mask == $past(regWdata[2:0]))
        else $error("mask write lost");

    a_edge_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wrEdge |=> s_q.edgeSel == $past(regWdata[0]))
        else $error("edge select write lost");

    c_timer0_req: cover property (@(posedge core_clk) disable iff (!rstn)
        timer0Overflow ##1 s_q.coreCtrl[irq_gate_pkg::MASTER_BIT]
        && s_q.coreCtrl[irq_gate_pkg::T0EN_BIT] ##1 cpuIrq);
    c_periph_req: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(cpuIrq) && s_q.coreCtrl[irq_gate_pkg::GROUP_BIT]);
    c_ext_edge: cover property (@(posedge core_clk) disable iff (!rstn) extEdge);
    c_irq_line: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irqLine));
    c_port_change: cover property (@(posedge core_clk) disable iff (!rstn) portChange);
endmodule

// ---- dv/irq_source_model.sv ----
/*
 * Stand-in for timer0, the peripheral event sources and the external pins.
 * Assumes its tasks are called from one bench process that follows core_clk.
 */
module irq_source_model (
    input  wire logic       core_clk,
    output logic            timer0Overflow,
    output logic      [4:0] periphEvent,
    output logic            extIrqPin,
    output logic      [3:0] portChangePins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        timer0Overflow = 1'b0;
        periphEvent    = 5'h00;
        extIrqPin      = 1'b0;
        portChangePins = 4'h0;
    end
    // Events are single-cycle pulses, whatever any enable says.
    task automatic pulse(input logic t0, input logic [4:0] ev);
        @(posedge core_clk);
        timer0Overflow <= t0;
        periphEvent    <= ev;
        @(posedge core_clk);
        timer0Overflow <= 1'b0;
        periphEvent    <= 5'h00;
    endtask
    // Pins are held long enough to pass the two-flop synchroniser.
    task automatic pins(input logic ext, input logic [3:0] port);
        @(posedge core_clk);
        extIrqPin      <= ext;
        portChangePins <= port;
        repeat (6) @(posedge core_clk);
    endtask
endmodule

// ---- dv/core_interrupt_gating_tb.sv ----
/*
 * Self-checking bench for the interrupt gating block.
 * Assumes the source model drives every event input and pin.
 */
module core_interrupt_gating_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk;
    logic       rstn;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdata;
    logic       timer0Overflow;
    logic [4:0] periphEvent;
    logic       extIrqPin;
    logic [3:0] portChangePins;
    logic       cpuIrq;
    logic       irqLine;
    int         nErrors;
    int         samplesChecked;
    logic [7:0] enBits [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40};
    core_interrupt_gating core_interrupt_gating_inst (.core_clk(core_clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .timer0Overflow(timer0Overflow), .periphEvent(periphEvent),
        .extIrqPin(extIrqPin), .portChangePins(portChangePins), .cpuIrq(cpuIrq),
        .irqLine(irqLine));
    irq_source_model irq_source_model_inst (.core_clk(core_clk),
        .timer0Overflow(timer0Overflow), .periphEvent(periphEvent),
        .extIrqPin(extIrqPin), .portChangePins(portChangePins));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic printVerdict();
        if (nErrors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    task automatic irq(input logic exp, input logic line);
        idle(3);
        chk({6'h00, irqLine, cpuIrq}, {6'h00, line, exp});
    endtask
    task automatic resetAndMask();
        rd(8'h0b, 8'h00);
        rd(8'h92, 8'h01);
        rd(8'h50, 8'h00);
        wr(8'h8c, 8'hff);
        rd(8'h8c, 8'h4f);
    endtask
    task automatic timer0Path();
        irq_source_model_inst.pulse(1'b1, 5'h00);
        idle(12);
        rd(8'h0b, 8'h04);
        wr(8'h0b, 8'h24);
        irq(1'b0, 1'b0);
        wr(8'h0b, 8'ha4);
        irq(1'b1, 1'b0);
        wr(8'h0b, 8'h20);
        irq(1'b0, 1'b0);
        rd(8'h0b, 8'h20);
    endtask
    task automatic periphPath();
        wr(8'h93, 8'h1f);
        wr(8'h8c, 8'h01);
        wr(8'h0b, 8'h80);
        irq_source_model_inst.pulse(1'b0, 5'h01);
        irq(1'b0, 1'b0);
        rd(8'h93, 8'h01);
        wr(8'h93, 8'h01);
        wr(8'h0b, 8'hc0);
        for (int i = 0; i < 5; i++) begin
            wr(8'h8c, enBits[i]);
            irq_source_model_inst.pulse(1'b0, 5'h01 << i);
            irq(1'b1, 1'b0);
            wr(8'h93, 8'h01 << i);
            irq(1'b0, 1'b0);
        end
    endtask
    task automatic pinPath();
        wr(8'h0b, 8'h90);
        irq_source_model_inst.pins(1'b1, 4'h0);
        rd(8'h0b, 8'h92);
        irq(1'b1, 1'b0);
        wr(8'h0b, 8'h90);
        irq_source_model_inst.pins(1'b0, 4'h0);
        rd(8'h0b, 8'h90);
        wr(8'h92, 8'h00);
        irq_source_model_inst.pins(1'b1, 4'h0);
        rd(8'h0b, 8'h90);
        irq_source_model_inst.pins(1'b0, 4'h0);
        rd(8'h0b, 8'h92);
        wr(8'h0b, 8'h88);
        irq_source_model_inst.pins(1'b0, 4'h8);
        rd(8'h0b, 8'h89);
    endtask
    // Status and mask give the sticky interrupt line beside the CPU request.
    task automatic statusLine();
        wr(8'h0b, 8'h00);
        rd(8'h90, 8'h07);
        wr(8'h91, 8'h04);
        irq(1'b0, 1'b1);
        wr(8'h90, 8'h04);
        irq(1'b0, 1'b0);
        rd(8'h90, 8'h03);
    endtask
    initial begin
        rstn     = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
        nErrors  = 0;
        samplesChecked = 0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        idle(5);
        resetAndMask();
        timer0Path();
        periphPath();
        pinPath();
        statusLine();
        printVerdict();
    end
    initial begin
        #200us;
        nErrors++;
        printVerdict();
    end
endmodule
